//--- gpc_consts.svh
// Purpose: Register offsets, field positions and reset values of the GPIO ports.
// Assumes: Byte-wide internal data bus with an 8-bit register address.
// Notes:   Definitions only.
`ifndef GPC_CONSTS_SVH
`define GPC_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------------
`define GPC_ADDR_P1_DATA      8'h20
`define GPC_ADDR_P1_DIR       8'h21
`define GPC_ADDR_P1_PULLUP    8'h22
`define GPC_ADDR_P1_DIGSEL    8'h23
`define GPC_ADDR_P2_DATA      8'h24
`define GPC_ADDR_P2_DIR       8'h25
`define GPC_ADDR_P2_PULLUP    8'h26
`define GPC_ADDR_P2_MODE      8'h27
`define GPC_ADDR_P3_DATA      8'h28

// ----------------------------------------------------------------------------
// Mode register fields
// ----------------------------------------------------------------------------
`define GPC_MODE_BUZZER_BIT   7
`define GPC_MODE_PDM_BIT      4
`define GPC_MODE_IRQ1_HI      3
`define GPC_MODE_IRQ1_LO      2
`define GPC_MODE_IRQ0_HI      1
`define GPC_MODE_IRQ0_LO      0
`define GPC_MODE_IMPL_MASK    8'h9F
`define GPC_BUZZER_PIN        7
`define GPC_PDM_PIN           2
`define GPC_P3_WIDTH          4

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define GPC_RESET_CTRL        8'h00

`endif

//--- gpc_pkg.sv
// Purpose: Types shared by the GPIO port block.
// Assumes: Nothing beyond the constants header.
// Notes:   Trigger codes 10 and 11 both mean any change.
package gpc_pkg;

  typedef enum logic [1:0] {
    GPC_TRIG_FALL  = 2'h0,
    GPC_TRIG_RISE  = 2'h1,
    GPC_TRIG_ANY_A = 2'h3,
    GPC_TRIG_ANY_B = 2'h2
  } gpc_trig_type;

endpackage

//--- gpc_gpio.sv
// Purpose: Three GPIO ports with direction, pull-up, analog select and pin sharing.
// Assumes: One clock; pins are asynchronous and pass two flip-flops before use.
// Notes:   Data latches carry no reset, so they power up unknown.
`timescale 1ns/1ps
`include "gpc_consts.svh"

module gpc_gpio
  import gpc_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Internal register bus
  input  wire logic [7:0]  bus_addr,
  input  wire logic        bus_write,
  input  wire logic        bus_read,
  input  wire logic [7:0]  bus_wdata,
  output logic      [7:0]  bus_rdata,
  // Port 1 pins
  input  wire logic [7:0]  p1_in,
  output logic      [7:0]  p1_out,
  output logic      [7:0]  p1_oe_n,
  output logic      [7:0]  p1_pullup_en,
  output logic      [7:0]  p1_analog_en,
  // Port 2 pins
  input  wire logic [7:0]  p2_in,
  output logic      [7:0]  p2_out,
  output logic      [7:0]  p2_oe_n,
  output logic      [7:0]  p2_pullup_en,
  // Port 3 pins, direction comes from the p3_dir input, not a control register
  input  wire logic [3:0]  p3_in,
  input  wire logic [3:0]  p3_dir,
  output logic      [3:0]  p3_out,
  output logic      [3:0]  p3_oe_n,
  // Shared functions
  input  wire logic        buzzer_in,
  input  wire logic        pdm_in,
  output logic             pdm_enable,
  output logic      [1:0]  ext_irq_event
);

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  logic [7:0] p1_dir_reg;
  logic [7:0] p1_pullup_reg;
  logic [7:0] p1_digsel_reg;
  logic [7:0] p2_dir_reg;
  logic [7:0] p2_pullup_reg;
  logic [7:0] p2_mode_reg;
  logic [7:0] p1_data_reg;
  logic [7:0] p2_data_reg;
  logic [3:0] p3_data_reg;
  logic [7:0] p1_meta_reg;
  logic [7:0] p1_sync_reg;
  logic [7:0] p2_meta_reg;
  logic [7:0] p2_sync_reg;
  logic [3:0] p3_meta_reg;
  logic [3:0] p3_sync_reg;
  logic [1:0] irq_prev_reg;
  logic [1:0] irq_next;
  logic [7:0] rdata_next;
  logic [7:0] mode_wr;

  function automatic logic hit(input logic [7:0] a);
    hit = bus_write && (bus_addr == a);
  endfunction

  function automatic logic trig_hit(input gpc_trig_type mode, input logic prev,
                                    input logic cur);
    unique case (mode)
      GPC_TRIG_FALL:  trig_hit = prev & ~cur;
      GPC_TRIG_RISE:  trig_hit = ~prev & cur;
      GPC_TRIG_ANY_A: trig_hit = prev ^ cur;
      GPC_TRIG_ANY_B: trig_hit = prev ^ cur;
    endcase
  endfunction

  assign mode_wr = bus_wdata & `GPC_MODE_IMPL_MASK;

  // --------------------------------------------------------------------------
  // Control registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      p1_dir_reg    <= `GPC_RESET_CTRL;
      p2_dir_reg    <= `GPC_RESET_CTRL;
      p1_pullup_reg <= `GPC_RESET_CTRL;
      p2_pullup_reg <= `GPC_RESET_CTRL;
      p1_digsel_reg <= `GPC_RESET_CTRL;
      p2_mode_reg   <= `GPC_RESET_CTRL;
    end else begin
      if (hit(`GPC_ADDR_P1_DIR)) p1_dir_reg <= bus_wdata;
      if (hit(`GPC_ADDR_P2_DIR)) p2_dir_reg <= bus_wdata;
      if (hit(`GPC_ADDR_P1_PULLUP)) p1_pullup_reg <= bus_wdata;
      if (hit(`GPC_ADDR_P2_PULLUP)) p2_pullup_reg <= bus_wdata;
      if (hit(`GPC_ADDR_P1_DIGSEL)) p1_digsel_reg <= bus_wdata;
      if (hit(`GPC_ADDR_P2_MODE)) p2_mode_reg <= mode_wr;
    end
  end

  // --------------------------------------------------------------------------
  // Output data latches
  // --------------------------------------------------------------------------
  // No reset: port 1 and 2 pins are inputs until software writes direction, or the port 2 mode bits for pins 7 and 2.
  always_ff @(posedge clock) begin
    if (hit(`GPC_ADDR_P1_DATA)) p1_data_reg <= bus_wdata;
    if (hit(`GPC_ADDR_P2_DATA)) p2_data_reg <= bus_wdata;
    if (hit(`GPC_ADDR_P3_DATA)) p3_data_reg <= bus_wdata[3:0];
  end

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      p1_meta_reg <= 8'h00;
      p1_sync_reg <= 8'h00;
      p2_meta_reg <= 8'h00;
      p2_sync_reg <= 8'h00;
      p3_meta_reg <= 4'h0;
      p3_sync_reg <= 4'h0;
    end else begin
      p1_meta_reg <= p1_in;
      p1_sync_reg <= p1_meta_reg;
      p2_meta_reg <= p2_in;
      p2_sync_reg <= p2_meta_reg;
      p3_meta_reg <= p3_in;
      p3_sync_reg <= p3_meta_reg;
    end
  end

  // --------------------------------------------------------------------------
  // Pin drivers
  // --------------------------------------------------------------------------
  always_comb begin
    p1_out       = p1_data_reg;
    p1_oe_n      = ~p1_dir_reg;
    p1_pullup_en = p1_pullup_reg;
    p1_analog_en = ~p1_digsel_reg;
    p2_out       = p2_data_reg;
    p2_oe_n      = ~p2_dir_reg;
    p2_pullup_en = p2_pullup_reg;
    p3_out       = p3_data_reg;
    p3_oe_n      = ~p3_dir;
    pdm_enable   = p2_mode_reg[`GPC_MODE_PDM_BIT];
    if (p2_mode_reg[`GPC_MODE_BUZZER_BIT]) begin
      p2_out[`GPC_BUZZER_PIN]  = buzzer_in;
      p2_oe_n[`GPC_BUZZER_PIN] = 1'b0;
    end
    if (p2_mode_reg[`GPC_MODE_PDM_BIT]) begin
      p2_out[`GPC_PDM_PIN]  = pdm_in;
      p2_oe_n[`GPC_PDM_PIN] = 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // External interrupt edge detection
  // --------------------------------------------------------------------------
  // The previous level is taken from the second sync stage, never the first.
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_irq
      always_comb begin
        irq_next[gi] = trig_hit(gpc_trig_type'(p2_mode_reg[2*gi+1 -: 2]),
                                irq_prev_reg[gi], p2_sync_reg[gi]);
      end
    end
  endgenerate

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_prev_reg  <= 2'h0;
      ext_irq_event <= 2'h0;
    end else begin
      irq_prev_reg  <= p2_sync_reg[1:0];
      ext_irq_event <= irq_next;
    end
  end

  // --------------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------------
  always_comb begin
    rdata_next = 8'h00;
    unique case (bus_addr)
      `GPC_ADDR_P1_DATA:
        rdata_next = (p1_dir_reg & p1_data_reg)
                   | (~p1_dir_reg & p1_digsel_reg & p1_sync_reg);
      `GPC_ADDR_P1_DIR:    rdata_next = p1_dir_reg;
      `GPC_ADDR_P1_PULLUP: rdata_next = p1_pullup_reg;
      `GPC_ADDR_P1_DIGSEL: rdata_next = p1_digsel_reg;
      `GPC_ADDR_P2_DATA:
        rdata_next = (p2_dir_reg & p2_data_reg) | (~p2_dir_reg & p2_sync_reg);
      `GPC_ADDR_P2_DIR:    rdata_next = p2_dir_reg;
      `GPC_ADDR_P2_PULLUP: rdata_next = p2_pullup_reg;
      `GPC_ADDR_P2_MODE:   rdata_next = p2_mode_reg;
      `GPC_ADDR_P3_DATA:
        rdata_next = {4'h0, (p3_dir & p3_data_reg) | (~p3_dir & p3_sync_reg)};
      default:             rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bus_rdata <= 8'h00;
    end else if (bus_read) begin
      bus_rdata <= rdata_next;
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  dir_write_a: assert property (
    hit(`GPC_ADDR_P2_DIR) |=> p2_oe_n[5:3] == ~$past(bus_wdata[5:3]))
    else $error("Port 2 direction write not applied.");
  p1_dir_a: assert property (
    hit(`GPC_ADDR_P1_DIR) |=> p1_oe_n == ~$past(bus_wdata))
    else $error("Port 1 direction write not applied.");
  pullup_path_a: assert property (
    hit(`GPC_ADDR_P1_PULLUP) |=> p1_pullup_en == $past(bus_wdata))
    else $error("Pull-up enable does not follow write.");
  analog_sel_a: assert property (
    hit(`GPC_ADDR_P1_DIGSEL) |=> p1_analog_en == ~$past(bus_wdata))
    else $error("Analog select does not follow write.");
  p2_data_a: assert property (
    hit(`GPC_ADDR_P2_DATA) |=> p2_out[6:3] == $past(bus_wdata[6:3]))
    else $error("Port 2 data not latched.");
  p3_upper_a: assert property (
    bus_read && bus_addr == `GPC_ADDR_P3_DATA |=> bus_rdata[7:4] == 4'h0)
    else $error("Port 3 upper bits not zero.");
  buzzer_route_a: assert property (
    p2_mode_reg[7] |-> !p2_oe_n[7] && p2_out[7] == buzzer_in)
    else $error("Buzzer not routed to pin 7.");
  pdm_route_a: assert property (
    p2_mode_reg[4] |-> pdm_enable && !p2_oe_n[2] && p2_out[2] == pdm_in)
    else $error("PDM not routed to pin 2.");
  // The event flop is loaded on the edge that sees the fall, so it shows one edge later.
  irq1_fall_a: assert property (
    p2_mode_reg[3:2] == 2'h0 && $fell(p2_sync_reg[1]) |=> ext_irq_event[1])
    else $error("Interrupt 1 falling edge missed.");
  irq0_rise_a: assert property (
    ext_irq_event[0] && $past(p2_mode_reg[1:0]) == 2'h1
      |-> $past(p2_sync_reg[0]) && !$past(p2_sync_reg[0], 2))
    else $error("Interrupt 0 fired without rising edge.");
  p1_analog_rd_a: assert property (
    bus_read && bus_addr == `GPC_ADDR_P1_DATA && (p1_digsel_reg | p1_dir_reg) == 8'h00
      |=> bus_rdata == 8'h00)
    else $error("Analog pin leaked to data bus.");
  p2_input_rd_a: assert property (
    bus_read && bus_addr == `GPC_ADDR_P2_DATA && p2_dir_reg == 8'h00
      |=> bus_rdata == $past(p2_sync_reg))
    else $error("Input read does not return pin level.");

  buzzer_on_c: cover property (hit(`GPC_ADDR_P2_MODE) && bus_wdata[7] ##1 !p2_oe_n[7]);
  irq_any_c: cover property (p2_mode_reg[1] && ext_irq_event[0]);
  out_read_c: cover property (
    hit(`GPC_ADDR_P2_DATA) ##1 bus_read && bus_addr == `GPC_ADDR_P2_DATA);

endmodule // gpc_gpio

//--- gpc_pins.sv
// Purpose: Pads of the three ports as seen from the board.
// Assumes: Bench may drive any pad; where the device drives, the device level wins.
// Notes:   A floating pad without pull-up toggles, so no stale level reads back.
`timescale 1ns/1ps
module gpc_pins (
  // Clock
  input  wire logic        clock,
  // Device side
  input  wire logic [19:0] pad_out,
  input  wire logic [19:0] pad_oe_n,
  input  wire logic [19:0] pad_pu,
  // Board side
  input  wire logic [19:0] ext_val,
  input  wire logic [19:0] ext_en,
  output logic      [19:0] pad_in
);
  logic flip_reg = 1'b0;
  always @(posedge clock) flip_reg <= ~flip_reg;
  always_comb begin
    for (int i = 0; i < 20; i++) begin
      if (!pad_oe_n[i]) pad_in[i] = pad_out[i];
      else if (ext_en[i]) pad_in[i] = ext_val[i];
      else if (pad_pu[i]) pad_in[i] = 1'b1;
      else pad_in[i] = flip_reg;
    end
  end
endmodule // gpc_pins

//--- gpc_gpio_tb.sv
// Purpose: Self-checking bench for the GPIO ports.
// Assumes: Pads come from gpc_pins.
// Notes:   Port 2 data is read only while its shared pins act as GPIO.
`timescale 1ns/1ps
module gpc_gpio_tb;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  bus_addr, bus_wdata, bus_rdata, p1_out, p1_oe_n, p1_pullup_en;
  logic [7:0]  p1_analog_en, p2_out, p2_oe_n, p2_pullup_en;
  logic        bus_write, bus_read, buzzer_in, pdm_in, pdm_enable;
  logic [3:0]  p3_dir, p3_out, p3_oe_n;
  logic [1:0]  ext_irq_event;
  logic [19:0] pad_in, ext_val, ext_en;
  logic [7:0]  mdl [0:255];
  logic [7:0]  regs [7] = '{8'h21, 8'h22, 8'h23, 8'h25, 8'h26, 8'h27, 8'h30};
  int          error_cnt, check_count, cyc, irq0, irq1, b0, b1;
  always #5 clock = ~clock;
  gpc_gpio i_dut (.clock(clock), .rst_n(rst_n), .bus_addr(bus_addr), .bus_write(bus_write),
    .bus_read(bus_read), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .p1_in(pad_in[7:0]),
    .p1_out(p1_out), .p1_oe_n(p1_oe_n), .p1_pullup_en(p1_pullup_en),
    .p1_analog_en(p1_analog_en), .p2_in(pad_in[15:8]), .p2_out(p2_out), .p2_oe_n(p2_oe_n),
    .p2_pullup_en(p2_pullup_en), .p3_in(pad_in[19:16]), .p3_dir(p3_dir), .p3_out(p3_out),
    .p3_oe_n(p3_oe_n), .buzzer_in(buzzer_in), .pdm_in(pdm_in), .pdm_enable(pdm_enable),
    .ext_irq_event(ext_irq_event));
  gpc_pins i_pins (.clock(clock), .pad_out({p3_out, p2_out, p1_out}),
    .pad_oe_n({p3_oe_n, p2_oe_n, p1_oe_n}), .pad_pu({4'h0, p2_pullup_en, p1_pullup_en}),
    .ext_val(ext_val), .ext_en(ext_en), .pad_in(pad_in));
  // Ceiling well above the few hundred cycles the tests need.
  always @(posedge clock) begin
    cyc <= cyc + 1;
    irq0 <= irq0 + (ext_irq_event[0] === 1'b1);
    irq1 <= irq1 + (ext_irq_event[1] === 1'b1);
    if (cyc == 3000) begin
      error_cnt++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    bus_addr <= a;
    bus_wdata <= d;
    bus_write <= 1'b1;
    @(posedge clock);
    bus_write <= 1'b0;
    if (a >= 8'h20 && a <= 8'h28)
      mdl[a] = d & (a == 8'h27 ? 8'h9F : a == 8'h28 ? 8'h0F : 8'hFF);
  endtask
  task automatic rd(input logic [7:0] a);
    logic [19:0] pin;
    logic [7:0]  e;
    pin = (ext_val & ext_en) | ({4'h0, mdl[8'h26], mdl[8'h22]} & ~ext_en);
    case (a)
      8'h20: e = (mdl[a] & mdl[8'h21]) | (pin[7:0] & ~mdl[8'h21] & mdl[8'h23]);
      8'h24: e = (mdl[a] & mdl[8'h25]) | (pin[15:8] & ~mdl[8'h25]);
      8'h28: e = {4'h0, (mdl[a][3:0] & p3_dir) | (pin[19:16] & ~p3_dir)};
      default: e = mdl[a];
    endcase
    @(posedge clock);
    bus_addr <= a;
    bus_read <= 1'b1;
    @(posedge clock);
    bus_read <= 1'b0;
    @(posedge clock);
    chk(bus_rdata, e);
  endtask
  initial begin
    {bus_addr, bus_wdata, bus_write, bus_read, p3_dir, buzzer_in, pdm_in} = '0;
    ext_val = '0;
    ext_en = '1;
    foreach (mdl[i]) mdl[i] = 8'h00;
    void'($urandom(95608));
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    for (int a = 8'h20; a <= 8'h27; a++) rd(8'(a));
    chk(p1_oe_n & p2_oe_n & p1_analog_en, 8'hFF);
    chk(p1_pullup_en | p2_pullup_en | {7'h0, pdm_enable}, 8'h00);
    $display("test reset done");
    // Known data first, so pins turned to output never carry unknowns into the syncs.
    wr(8'h20, 8'h00);
    wr(8'h24, 8'h00);
    wr(8'h28, 8'h00);
    repeat (3) begin
      foreach (regs[i]) begin
        wr(regs[i], 8'($urandom));
        rd(regs[i]);
      end
      chk(p1_oe_n, ~mdl[8'h21]);
      chk(p1_pullup_en, mdl[8'h22]);
      chk(p1_analog_en, ~mdl[8'h23]);
      chk(p2_oe_n, ~mdl[8'h25] & ~{mdl[8'h27][7], 4'h0, mdl[8'h27][4], 2'h0});
      chk(p2_pullup_en, mdl[8'h26]);
      chk({7'h0, pdm_enable}, {7'h0, mdl[8'h27][4]});
    end
    wr(8'h27, 8'h00);
    wr(8'h25, 8'h00);
    wr(8'h26, 8'hFF);
    ext_en[15:8] <= 8'h00;
    repeat (3) @(posedge clock);
    rd(8'h24);
    ext_en <= '1;
    $display("test control done");
    repeat (4) begin
      ext_val <= 20'($urandom);
      p3_dir <= 4'($urandom);
      wr(8'h21, 8'($urandom));
      wr(8'h23, 8'($urandom));
      wr(8'h25, 8'($urandom));
      wr(8'h20, 8'($urandom));
      wr(8'h24, 8'($urandom));
      wr(8'h28, 8'($urandom));
      repeat (3) @(posedge clock);
      rd(8'h20);
      rd(8'h24);
      rd(8'h28);
      chk(p1_out & mdl[8'h21], mdl[8'h20] & mdl[8'h21]);
      chk(p2_out & mdl[8'h25], mdl[8'h24] & mdl[8'h25]);
      chk({4'h0, p3_out & p3_dir}, {4'h0, mdl[8'h28][3:0] & p3_dir});
      chk({4'h0, p3_oe_n}, {4'h0, ~p3_dir});
    end
    $display("test data done");
    wr(8'h27, 8'h90);
    repeat (4) begin
      buzzer_in <= 1'($urandom);
      pdm_in <= 1'($urandom);
      @(posedge clock);
      chk({4'h0, p2_out[7], p2_out[2], p2_oe_n[7], p2_oe_n[2]},
             {4'h0, buzzer_in, pdm_in, 2'h0});
    end
    wr(8'h27, 8'h00);
    @(posedge clock);
    chk(p2_oe_n, ~mdl[8'h25]);
    $display("test sharing done");
    wr(8'h25, 8'h00);
    for (int m = 0; m < 4; m++) begin
      ext_val[9:8] <= 2'h0;
      wr(8'h27, 8'(m * 5));
      repeat (6) @(posedge clock);
      b0 = irq0;
      b1 = irq1;
      ext_val[9:8] <= 2'h3;
      repeat (8) @(posedge clock);
      ext_val[9:8] <= 2'h0;
      repeat (8) @(posedge clock);
      chk(8'(irq0 - b0), m < 2 ? 8'h01 : 8'h02);
      chk(8'(irq1 - b1), m < 2 ? 8'h01 : 8'h02);
    end
    $display("test trigger done");
    stop_test();
  end
endmodule // gpc_gpio_tb
